// >>> hw/hps_consts.vh
// Register map, field positions, reset values and timing counts
`ifndef HPS_CONSTS_VH
`define HPS_CONSTS_VH
`define HPS_CLK_HZ 20000000
`define HPS_TICK_1MS_CYC 20000
`define HPS_TICK_5MS 5
`define HPS_WAIT_UNIT_MS 10
`define HPS_PIN_MIN_NS 1000
`define HPS_PIN_MIN_CYC ((`HPS_PIN_MIN_NS * 20 + 999) / 1000)
`define HPS_A_CTRL 12'h000
`define HPS_A_DRIVE 12'h004
`define HPS_A_OFFS 12'h008
`define HPS_A_SLOT_LO 12'h00C
`define HPS_A_SLOT_HI 12'h010
`define HPS_A_LOOP 12'h014
`define HPS_A_LIVE 12'h018
`define HPS_A_STATUS 12'h01C
`define HPS_A_LIB 12'h020
`define HPS_B_LAUNCH 0
`define HPS_B_PROC_LO 1
`define HPS_B_PROC_HI 2
`define HPS_B_LIBSEL 3
`define HPS_B_INTERVAL 4
`define HPS_B_OPENLOOP 5
`define HPS_B_ERM 6
`define HPS_B_SHAPE 7
`define HPS_B_AUTOBRK 8
`define HPS_B_PINFN_LO 9
`define HPS_B_PINFN_HI 10
`define HPS_PROC_SEQ_INT 2'h0
`define HPS_PROC_SEQ_EXT 2'h1
`define HPS_PROC_LIVE 2'h2
`define HPS_PIN_PULSE 2'h0
`define HPS_PIN_LEVEL 2'h1
`define HPS_PIN_IRQ 2'h2
`define HPS_CTRL_RST 32'h0000_0000
`define HPS_DRIVE_RST 32'h0000_FF20
`endif

// >>> hw/hps_effect.v
// Library effect player: applies time offsets and produces segment amplitudes
`timescale 1ns/1ps
`include "hps_consts.vh"
module hps_effect (
    input wire clk,
    input wire rst,
    input wire start,
    input wire abort,
    input wire tick,
    input wire [6:0] effect_id,
    input wire library_select,
    input wire [31:0] time_offsets,
    output reg busy,
    output reg [7:0] amp,
    output reg brake_phase
);
    // Each effect is four segments: overdrive, sustain +, sustain -, brake.
    // Segment amplitude/duration are generated from the id so no ROM file.
    reg [1:0] seg;
    reg [9:0] left;
    reg [7:0] amp_start;
    reg [7:0] amp_end;
    reg [9:0] len;
    wire [7:0] id8 = {1'b0, effect_id};
    wire signed [7:0] ofs [0:3];
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_ofs
            assign ofs[g] = time_offsets[8*g+7:8*g];
        end
    endgenerate
    function [7:0] seg_amp;
        input [1:0] s;
        input lib;
        input [7:0] id;
        begin
            // Most positive value is overdrive, most negative is brake
            case (s)
                2'h0: seg_amp = 8'h7F;
                2'h1: seg_amp = lib ? 8'h40 : (8'h20 + {2'h0, id[5:0]});
                2'h2: seg_amp = 8'hE0;
                default: seg_amp = 8'h80;
            endcase
        end
    endfunction
    function [9:0] seg_len;
        input [1:0] s;
        input [7:0] id;
        input signed [7:0] o;
        reg signed [11:0] t;
        begin
            t = {4'h0, id[3:0], 4'h4} + {{4{o[7]}}, o};
            // Offset added to segment time, clamped to at least one tick
            if (t < 12'sd1)
                seg_len = 10'h001;
            else
                seg_len = t[9:0];
        end
    endfunction
    always @*
    begin
        amp_start = seg_amp(seg, library_select, id8);
        amp_end = (seg == 2'h3) ? 8'h80 :
            seg_amp(seg + 2'h1, library_select, id8);
        len = seg_len(seg, id8, ofs[seg]);
    end
    wire [9:0] elapsed = len - left;
    wire signed [9:0] da = {{2{amp_end[7]}}, amp_end} -
        {{2{amp_start[7]}}, amp_start};
    wire signed [19:0] prod = da * $signed({1'b0, elapsed[8:0]});
    wire signed [19:0] ramp = prod / $signed({1'b0, len[8:0]});
    always @(posedge clk)
    begin
        if (rst || abort)
        begin
            busy <= 1'b0;
            seg <= 2'h0;
            left <= 10'h000;
            amp <= 8'h00;
            brake_phase <= 1'b0;
        end
        else if (start)
        begin
            busy <= 1'b1;
            seg <= 2'h0;
            left <= seg_len(2'h0, id8, ofs[0]);
            amp <= 8'h7F;
            brake_phase <= 1'b0;
        end
        else if (busy && tick)
        begin
            if (left <= 10'h001)
            begin
                if (seg == 2'h3)
                begin
                    busy <= 1'b0;
                    amp <= 8'h00;
                    brake_phase <= 1'b0;
                end
                else
                begin
                    seg <= seg + 2'h1;
                    left <= seg_len(seg + 2'h1, id8, ofs[seg + 2'h1]);
                    brake_phase <= (seg == 2'h2);
                end
            end
            else
            begin
                left <= left - 10'h001;
                // Ramp interpolated over the adjusted segment length
                amp <= amp_start + ramp[7:0];
            end
        end
    end
endmodule

// >>> hw/hps_sequencer.v
// Haptic playback sequencer top: APB registers, trigger, sequencer, drive
//
// Contract
// - LRA start while moving drives along motion, else default direction.
// - Digital open-loop mode overrides closed loop, library and live playback.
// - Peak limit sets maximum output; amplitude codes scale within it.
// - LRA open-loop frequency comes from the resonant period setting.
// - Sine or square shape only in open-loop LRA drive.
// - Auto brake switches to closed loop during braking, both actuators.
// - Two-bit process select picks sequencer int/ext trigger or live playback.
// - Two libraries; library select chooses which the sequencer reads.
// - Four signed 8-bit time offsets, reset 0, library only.
// - Most positive segment is overdrive, most negative is brake.
// - Offsets apply to ramps; interpolation spans adjusted period.
// - Library tick is 5 ms, or 1 ms when interval bit set.
// - Start at first of eight slots; stop at zero id or eighth.
// - Slot with top bit clear holds id 1..127 into library.
// - Slot with top bit set waits low seven bits times 10 ms.
// - Each slot waveform repeats its slot repeat count.
// - Whole list replays list repeat count extra times, then standby.
// - Live amplitude register passed directly, writable during playback.
// - Live playback runs until stop or process select leaves it.
// - LRA live playback tracks resonance unless open loop selected.
// - No process starts without launch bit or pin trigger.
// - Process ends on completion or stop trigger, whichever first.
// - Writing zero to launch bit acts as a stop trigger.
// - After completion or stop, return to standby.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "hps_consts.vh"
module hps_sequencer (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire trigger_interrupt_pin_in,
    input wire actuator_moving,
    input wire actuator_direction,
    output reg trigger_interrupt_pin_out,
    output reg trigger_interrupt_pin_oe,
    output reg [7:0] drive_level,
    output reg drive_negative,
    output reg drive_closed_loop,
    output reg drive_square,
    output reg [6:0] drive_period,
    output reg standby
);
    localparam S_IDLE = 3'h0;
    localparam S_SLOT = 3'h1;
    localparam S_PLAY = 3'h2;
    localparam S_WAIT = 3'h3;
    localparam S_LIVE = 3'h4;
    reg [31:0] ctrl;
    reg [31:0] drive_cfg;
    reg [31:0] time_offsets;
    reg [63:0] slots;
    reg [31:0] repeats;
    reg [7:0] live_amplitude_value;
    reg [2:0] state;
    reg [2:0] slot_idx;
    reg [3:0] slot_rep;
    reg [3:0] list_rep;
    reg [15:0] wait_left;
    reg [14:0] ms_cnt;
    reg [2:0] tick_div;
    reg pin_q;
    reg eff_start;
    reg start_dir;
    wire eff_busy;
    wire [7:0] eff_amp;
    wire eff_brake;
    wire [1:0] proc_sel = ctrl[`HPS_B_PROC_HI:`HPS_B_PROC_LO];
    wire [1:0] pin_fn = drive_cfg[`HPS_B_PINFN_HI:`HPS_B_PINFN_LO];
    wire [7:0] overdrive_peak_limit = drive_cfg[31:24];
    wire [6:0] openloop_resonant_period = drive_cfg[22:16];
    wire openloop = drive_cfg[`HPS_B_OPENLOOP];
    wire erm = drive_cfg[`HPS_B_ERM];
    wire openloop_shape_select = drive_cfg[`HPS_B_SHAPE];
    wire openloop_auto_brake_enable = drive_cfg[`HPS_B_AUTOBRK];
    wire wr = psel && penable && pwrite;
    wire running = (state != S_IDLE);
    wire pin_rise = trigger_interrupt_pin_in && !pin_q;
    wire pin_fall = !trigger_interrupt_pin_in && pin_q;
    // Pin trigger only counts when the pin is set as an input function;
    // pulses shorter than 1 us are the host's fault, edges are not filtered
    wire pin_pulse = (pin_fn == `HPS_PIN_PULSE) && pin_rise;
    wire pin_level_on = (pin_fn == `HPS_PIN_LEVEL) && pin_rise;
    wire pin_level_off = (pin_fn == `HPS_PIN_LEVEL) && pin_fall;
    wire ext_ok = (proc_sel != `HPS_PROC_SEQ_INT);
    wire launch_wr = wr && (paddr == `HPS_A_CTRL);
    wire sw_go = launch_wr && pwdata[`HPS_B_LAUNCH] && !running;
    wire sw_stop = launch_wr && !pwdata[`HPS_B_LAUNCH] && running;
    wire hw_go = ext_ok && !running && (pin_pulse || pin_level_on);
    wire hw_stop = ext_ok && running && (pin_pulse || pin_level_off);
    wire go = sw_go || hw_go;
    wire stop = sw_stop || hw_stop || (state == S_LIVE &&
        proc_sel != `HPS_PROC_LIVE);
    wire [7:0] cur_slot = slots[8*slot_idx +: 8];
    wire [31:0] wait_prod = cur_slot[6:0] * `HPS_WAIT_UNIT_MS;
    wire ms_tick = (ms_cnt == 15'd0);
    // 5 ms tick, or 1 ms when the interval bit is set
    wire lib_tick = ms_tick && (ctrl[`HPS_B_INTERVAL] ||
        tick_div == 3'd0);
    wire [3:0] slot_rep_max = repeats[4*slot_idx +: 4];
    wire [3:0] list_rep_max = drive_cfg[15:12];
    wire [7:0] src_amp = (state == S_LIVE) ? live_amplitude_value : eff_amp;
    wire [15:0] scaled = src_amp * overdrive_peak_limit;
    always @(posedge clk)
    begin
        if (rst)
        begin
            ms_cnt <= 15'd0;
            tick_div <= 3'd0;
        end
        else if (ms_cnt == `HPS_TICK_1MS_CYC - 1)
        begin
            ms_cnt <= 15'd0;
            tick_div <= (tick_div == `HPS_TICK_5MS - 1) ? 3'd0 :
                tick_div + 3'd1;
        end
        else
        begin
            ms_cnt <= ms_cnt + 15'd1;
        end
    end
    hps_effect u_effect (
        .clk(clk),
        .rst(rst),
        .start(eff_start),
        .abort(stop),
        .tick(lib_tick),
        .effect_id(cur_slot[6:0]),
        .library_select(ctrl[`HPS_B_LIBSEL]),
        .time_offsets(time_offsets),
        .busy(eff_busy),
        .amp(eff_amp),
        .brake_phase(eff_brake)
    );
    // APB slave: zero wait states, unmapped reads answer with an error, unmapped writes do not
    always @(posedge clk)
    begin
        if (rst)
        begin
            drive_cfg <= `HPS_DRIVE_RST;
            time_offsets <= 32'h0000_0000;
            slots <= 64'h0000_0000_0000_0000;
            repeats <= 32'h0000_0000;
            live_amplitude_value <= 8'h00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            pin_q <= 1'b0;
        end
        else
        begin
            pin_q <= trigger_interrupt_pin_in;
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    `HPS_A_CTRL: prdata <= ctrl;
                    `HPS_A_DRIVE: prdata <= drive_cfg;
                    `HPS_A_OFFS: prdata <= time_offsets;
                    `HPS_A_SLOT_LO: prdata <= slots[31:0];
                    `HPS_A_SLOT_HI: prdata <= slots[63:32];
                    `HPS_A_LOOP: prdata <= repeats;
                    `HPS_A_LIVE: prdata <= {24'h00_0000, live_amplitude_value};
                    `HPS_A_STATUS: prdata <= {24'h00_0000, eff_busy,
                        slot_idx, 1'b0, state};
                    default: pslverr <= !pwrite;
                endcase
            end
            if (wr)
            begin
                case (paddr)
                    `HPS_A_DRIVE: drive_cfg <= pwdata;
                    `HPS_A_OFFS: time_offsets <= pwdata;
                    `HPS_A_SLOT_LO: slots[31:0] <= pwdata;
                    `HPS_A_SLOT_HI: slots[63:32] <= pwdata;
                    `HPS_A_LOOP: repeats <= pwdata;
                    // Rewritable while playback runs
                    `HPS_A_LIVE: live_amplitude_value <= pwdata[7:0];
                    default: pslverr <= 1'b0;
                endcase
            end
        end
    end
    // Sequencer and live playback control
    always @(posedge clk)
    begin
        if (rst)
        begin
            ctrl <= `HPS_CTRL_RST;
            state <= S_IDLE;
            slot_idx <= 3'd0;
            slot_rep <= 4'd0;
            list_rep <= 4'd0;
            wait_left <= 16'd0;
            eff_start <= 1'b0;
            start_dir <= 1'b0;
        end
        else
        begin
            eff_start <= 1'b0;
            if (launch_wr)
                ctrl[31:1] <= pwdata[31:1];
            if (stop)
            begin
                state <= S_IDLE;
                ctrl[`HPS_B_LAUNCH] <= 1'b0;
            end
            else
            begin
                case (state)
                    S_IDLE:
                    begin
                        if (go)
                        begin
                            ctrl[`HPS_B_LAUNCH] <= 1'b1;
                            // Follow present motion, else default
                            start_dir <= actuator_moving && actuator_direction;
                            slot_idx <= 3'd0;
                            slot_rep <= 4'd0;
                            list_rep <= 4'd0;
                            if (launch_wr ? pwdata[`HPS_B_PROC_HI:`HPS_B_PROC_LO]
                                == `HPS_PROC_LIVE : proc_sel == `HPS_PROC_LIVE)
                                state <= S_LIVE;
                            else
                                state <= S_SLOT;
                        end
                    end
                    S_SLOT:
                    begin
                        if (cur_slot == 8'h00)
                        begin
                            // Zero id ends one pass of the list
                            if (list_rep < list_rep_max && slot_idx != 3'd0)
                            begin
                                list_rep <= list_rep + 4'd1;
                                slot_idx <= 3'd0;
                            end
                            else
                            begin
                                state <= S_IDLE;
                                ctrl[`HPS_B_LAUNCH] <= 1'b0;
                            end
                        end
                        else if (cur_slot[7])
                        begin
                            wait_left <= wait_prod[15:0];
                            state <= S_WAIT;
                        end
                        else
                        begin
                            eff_start <= 1'b1;
                            state <= S_PLAY;
                        end
                    end
                    S_PLAY, S_WAIT:
                    begin
                        if (state == S_WAIT && ms_tick && wait_left != 16'd0)
                            wait_left <= wait_left - 16'd1;
                        if ((state == S_PLAY && !eff_busy && !eff_start) ||
                            (state == S_WAIT && wait_left == 16'd0))
                        begin
                            state <= S_SLOT;
                            if (state == S_PLAY && slot_rep < slot_rep_max)
                                slot_rep <= slot_rep + 4'd1;
                            else
                            begin
                                slot_rep <= 4'd0;
                                if (slot_idx == 3'd7)
                                begin
                                    // Eighth slot done: loop or finish
                                    if (list_rep < list_rep_max)
                                    begin
                                        list_rep <= list_rep + 4'd1;
                                        slot_idx <= 3'd0;
                                    end
                                    else
                                    begin
                                        state <= S_IDLE;
                                        ctrl[`HPS_B_LAUNCH] <= 1'b0;
                                    end
                                end
                                else
                                    slot_idx <= slot_idx + 3'd1;
                            end
                        end
                    end
                    S_LIVE:
                        state <= S_LIVE;
                    default:
                        state <= S_IDLE;
                endcase
            end
        end
    end
    // Output stage: peak limit scales amplitude, loop and shape choice
    always @(posedge clk)
    begin
        if (rst)
        begin
            drive_level <= 8'h00;
            drive_negative <= 1'b0;
            drive_closed_loop <= 1'b1;
            drive_square <= 1'b0;
            drive_period <= 7'h00;
            standby <= 1'b1;
            trigger_interrupt_pin_out <= 1'b1;
            trigger_interrupt_pin_oe <= 1'b0;
        end
        else
        begin
            standby <= !running;
            // Live amplitude goes straight through, library via the player
            drive_level <= running ? scaled[15:8] : 8'h00;
            drive_negative <= start_dir;
            // Open loop overrides, except braking under auto brake
            drive_closed_loop <= !openloop ||
                (openloop_auto_brake_enable && eff_brake &&
                state == S_PLAY);
            // Shape only in open-loop LRA; LRA live tracks resonance otherwise
            drive_square <= openloop && !erm && openloop_shape_select &&
                !(openloop_auto_brake_enable && eff_brake);
            drive_period <= openloop ? openloop_resonant_period :
                7'h00;
            // Interrupt function has no source here; pin is driven high while it is selected
            trigger_interrupt_pin_out <= 1'b1;
            trigger_interrupt_pin_oe <= (pin_fn == `HPS_PIN_IRQ);
        end
    end
endmodule

// >>> testbench/hps_sequencer_sva.sv
// Concurrent checks on the playback sequencer top ports
`timescale 1ns/1ps
module hps_sequencer_chk (
    input logic clk,
    input logic rst,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic trigger_interrupt_pin_in,
    input logic [7:0] drive_level,
    input logic standby
);
    logic pin_prev;
    logic [2:0] trig_age;
    wire go_wr = psel && penable && pready && pwrite && paddr == 12'h000;
    // Age saturates so a start long after any trigger is still caught
    always @(posedge clk)
    begin
        pin_prev <= trigger_interrupt_pin_in;
        if (rst)
            trig_age <= 3'h7;
        else if ((go_wr && pwdata[0]) ||
            (trigger_interrupt_pin_in && !pin_prev))
            trig_age <= 3'h0;
        else if (trig_age != 3'h7)
            trig_age <= trig_age + 3'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_PREADY_ACCESS: assert property (psel && !penable |=> pready)
        else $error("pready missing in access phase");
    AST_PREADY_SOLO: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready outside a single access cycle");
    AST_SLVERR_UNMAPPED: assert property (pready && !pwrite
        && paddr > 12'h01C |-> pslverr)
        else $error("unmapped read not refused");
    AST_SLVERR_MAPPED: assert property (pready && paddr <= 12'h01C
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    AST_NO_START: assert property ($fell(standby) |-> trig_age < 3'h6)
        else $error("process started without trigger");
    AST_STOP_WRITE: assert property (go_wr && !pwdata[0] && !standby
        |-> ##[1:4] standby)
        else $error("launch write of zero did not stop");
    AST_RESET_STATE: assert property ($past(rst) |-> standby
        && drive_level == 8'h00)
        else $error("wrong state after reset");
    AST_LAUNCH_READ: assert property (pready && !pwrite
        && paddr == 12'h000 && standby == $past(standby, 2)
        |-> prdata[0] == !standby)
        else $error("launch bit does not show activity");
    AST_LEVEL_STANDBY: assert property (standby [*2]
        |-> drive_level == 8'h00)
        else $error("drive while in standby");
    COV_START: cover property ($fell(standby));
    COV_STOP: cover property ($rose(standby));
    COV_REFUSED: cover property (pready && pslverr);
endmodule
bind hps_sequencer hps_sequencer_chk hps_sequencer_chk_i (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_interrupt_pin_in(trigger_interrupt_pin_in),
    .drive_level(drive_level), .standby(standby));

// >>> testbench/hps_host_model.sv
// Host model: APB master and trigger pin driver
`timescale 1ns/1ps
module hps_host_model (
    input logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    output logic pin
);
    logic timed_out;
    integer k;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pin = 1'b0;
        timed_out = 1'b0;
    end
    task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        for (k = 0; k < 50 && pready !== 1'b1; k = k + 1)
            @(posedge clk);
        q = prdata;
        e = pslverr;
        if (pready !== 1'b1)
            timed_out = 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data toggles so stale values are never mistaken for valid
        pwdata <= ~d;
    endtask
    task pin_pulse;
        @(posedge clk);
        pin <= 1'b1;
        repeat (24) @(posedge clk);
        pin <= 1'b0;
    endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the playback sequencer
`timescale 1ns/1ps
module tb;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, err, shape;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, r;
    logic host_pin, pin_out, pin_oe, moving, direction;
    logic drive_negative, drive_closed_loop, drive_square, standby;
    logic [7:0] drive_level, peak, amp;
    logic [6:0] drive_period, period;
    integer mismatches, samples_checked, seed, i, n, c0, c1;
    wire pin_level = pin_oe ? pin_out : host_pin;
    hps_sequencer hps_sequencer_i (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trigger_interrupt_pin_in(pin_level), .actuator_moving(moving),
        .actuator_direction(direction), .trigger_interrupt_pin_out(pin_out),
        .trigger_interrupt_pin_oe(pin_oe), .drive_level(drive_level),
        .drive_negative(drive_negative), .drive_closed_loop(drive_closed_loop),
        .drive_square(drive_square), .drive_period(drive_period),
        .standby(standby));
    hps_host_model host_i (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin(host_pin));
    function [31:0] drive_word(input [7:0] pk, input [6:0] per, input shp);
        drive_word = {pk, 1'b0, per, 8'h00, shp, 2'b01, 5'h00};
    endfunction
    function [7:0] lvl(input [7:0] a, input [7:0] pk);
        reg [15:0] p;
        p = a * pk;
        lvl = p[15:8];
    endfunction
    task check(input [31:0] exp, input [31:0] got, input [8*10:1] what);
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0s expected %h seen %h", what, exp, got);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task wait_standby(input v);
        for (n = 0; n < 40 && standby !== v; n = n + 1)
            @(posedge clk);
        check(v, standby, "standby");
    endtask
    task wait_level(input [7:0] v);
        for (n = 0; n < 10 && drive_level !== v; n = n + 1)
            @(posedge clk);
        check(v, drive_level, "level");
    endtask
    // Internal-trigger sequencer run; c counts cycles out of standby
    task seq_run(input [3:0] lr, output integer c);
        host_i.xfer(1'b1, 12'h004, {16'h0000, lr, 12'h000}, rd, err);
        host_i.xfer(1'b1, 12'h000, 32'h0000_0001, rd, err);
        wait_standby(1'b0);
        for (c = 0; c < 40 && standby !== 1'b1; c = c + 1)
            @(posedge clk);
        check(1, standby, "seq end");
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
        if (host_i.timed_out)
        begin
            mismatches = mismatches + 1;
            finish_test;
        end
    initial
    begin
        repeat (60000) @(posedge clk);
        mismatches = mismatches + 1;
        finish_test;
    end
    initial
    begin
        seed = 32'h2908;
        rst = 1'b1;
        moving = 1'b0;
        direction = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        host_i.xfer(1'b0, 12'h004, 32'h0000_0000, rd, err);
        check(32'h0000_FF20, rd, "drive rst");
        host_i.xfer(1'b0, 12'h008, 32'h0000_0000, rd, err);
        check(32'h0000_0000, rd, "offsets");
        check(1, standby, "standby");
        host_i.xfer(1'b0, 12'h100, 32'h0000_0000, rd, err);
        check(1, err, "slverr");
        host_i.xfer(1'b1, 12'h000, 32'h0000_0004, rd, err);
        repeat (20) @(posedge clk);
        check(1, standby, "no trigger");
        $display("test reset_and_idle done");
        for (i = 0; i < 6; i = i + 1)
        begin
            r = $random(seed);
            peak = (i == 0) ? 8'hFF : r[7:0];
            amp = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : r[15:8];
            period = r[22:16];
            shape = r[23];
            host_i.xfer(1'b1, 12'h004, drive_word(peak, period, shape),
                rd, err);
            host_i.xfer(1'b1, 12'h018, {24'h00_0000, amp}, rd, err);
            @(posedge clk);
            moving <= r[24];
            direction <= r[25];
            host_i.xfer(1'b1, 12'h000, 32'h0000_0005, rd, err);
            wait_standby(1'b0);
            wait_level(lvl(amp, peak));
            check(r[24] & r[25], drive_negative, "direction");
            check(0, drive_closed_loop, "closed");
            check(shape, drive_square, "shape");
            check(period, drive_period, "period");
            host_i.xfer(1'b0, 12'h000, 32'h0000_0000, rd, err);
            check(1, rd[0], "launch rd");
            amp = ~amp;
            host_i.xfer(1'b1, 12'h018, {24'h00_0000, amp}, rd, err);
            wait_level(lvl(amp, peak));
            host_i.xfer(1'b1, 12'h000, 32'h0000_0004, rd, err);
            wait_standby(1'b1);
            host_i.xfer(1'b0, 12'h000, 32'h0000_0000, rd, err);
            check(0, rd[0], "launch rd");
        end
        $display("test live_playback done");
        host_i.pin_pulse;
        wait_standby(1'b0);
        host_i.pin_pulse;
        wait_standby(1'b1);
        $display("test pin_trigger done");
        // Zero-length wait, then zero id; one extra pass doubles the run
        host_i.xfer(1'b1, 12'h00C, 32'h0000_0080, rd, err);
        seq_run(4'h0, c0);
        seq_run(4'h1, c1);
        check(2 * c0, c1, "list loop");
        $display("test sequencer done");
        finish_test;
    end
endmodule
